// ==== logic/cia_consts.vh ====
// Constants for the customer-installation alarm monitor.
// Assumes a 32-bit Avalon-MM register port and a 20 MHz system clock.
`ifndef CIA_CONSTS_VH
`define CIA_CONSTS_VH
// Register indices; byte address is four times the index.
`define CIA_IDX_STATUS      12'h0b40
`define CIA_IDX_ENABLE      12'h0b41
`define CIA_IDX_DET_CTRL    12'h0b42
`define CIA_ADDR_W          14
// Field positions.
`define CIA_BIT_AIS_STATE   5
`define CIA_BIT_RAI_STATE   4
`define CIA_BIT_AIS_CHG     1
`define CIA_BIT_RAI_CHG     0
`define CIA_BIT_AIS_DET_EN  0
`define CIA_BIT_RAI_DET_EN  1
`define CIA_BIT_ESF         2
`define CIA_RESET_8         8'h00
// AIS-CI signature, first bit received in bit 0, and its repeat distance.
`define CIA_AIS_SIG         16'h7cff
`define CIA_AIS_PERIOD      386
// RAI message (00000000 11111111) and CI signature (00111110 111111111), LSB first.
`define CIA_RAI_MSG         16'h00ff
`define CIA_RAI_SIG         17'h0_7dff
// Timing in milliseconds and the clock rate in kHz.
`define CIA_CLK_KHZ         20000
`define CIA_RAI_MSG_MS      990
`define CIA_RAI_SIG_MS      90
`define CIA_RAI_PERIOD_MS   1080
`endif

// ==== logic/cia_ais_det.v ====
// AIS-CI detector: watches the received DS1 bit stream for the embedded signature.
// Assumes one bit per bit_en pulse, already framed, synchronous to clk.
`timescale 1ns/10ps
`include "cia_consts.vh"
module cia_ais_det #(
	parameter PERIOD   = `CIA_AIS_PERIOD,
	parameter LOCK_CNT = 4
) (
	input  wire clk,      // System clock.
	input  wire srst,     // Synchronous reset, active high.
	input  wire enable,   // Detection enable.
	input  wire bit_en,   // One-cycle pulse per line bit.
	input  wire bit_in,   // Received line bit.
	output reg  present_q // Condition present.
);
	reg [15:0] shift_q;
	reg [8:0]  since_q;
	reg [3:0]  hits_q;
	wire       sig_hit = (shift_q == `CIA_AIS_SIG);
	////////////////////////////////////////////////////////////////////////////////
	// Newest bit enters at the top so the first bit ends in bit 0; a signature
	// seen at exactly the repeat distance counts a hit, anything else resets.
	always @(posedge clk) begin
		if (srst || !enable) begin
			shift_q   <= 16'h0000;
			since_q   <= 9'h000;
			hits_q    <= 4'h0;
			present_q <= 1'b0;
		end else if (bit_en) begin
			shift_q <= {bit_in, shift_q[15:1]};
			since_q <= (since_q == 9'h1ff) ? since_q : since_q + 9'h001;
			if (sig_hit) begin
				since_q <= 9'h001;
				if (since_q == PERIOD[8:0]) begin
					if (hits_q != LOCK_CNT[3:0])
						hits_q <= hits_q + 4'h1;
					else
						present_q <= 1'b1;
				end else begin
					hits_q <= 4'h0;
				end
			end else if (since_q > PERIOD[8:0]) begin
				hits_q    <= 4'h0;
				present_q <= 1'b0;
			end
		end
	end
endmodule

// ==== logic/cia_rai_det.v ====
// RAI-CI detector: message for 0.99 s then CI signature for 90 ms, repeating.
// Assumes the ESF data-link bits arrive one per dl_en pulse, synchronous to clk.
`timescale 1ns/10ps
`include "cia_consts.vh"
module cia_rai_det #(
	parameter MSG_CYC = `CIA_RAI_MSG_MS * (`CIA_CLK_KHZ / 1000) * 1000,
	parameter SIG_CYC = `CIA_RAI_SIG_MS * (`CIA_CLK_KHZ / 1000) * 1000,
	parameter TOL_CYC = 100000
) (
	input  wire clk,      // System clock.
	input  wire srst,     // Synchronous reset, active high.
	input  wire enable,   // Detection enable and ESF mode together.
	input  wire dl_en,    // One-cycle pulse per data-link bit.
	input  wire dl_in,    // Data-link bit.
	output reg  present_q // Condition present.
);
	localparam ST_HUNT = 2'd0;
	localparam ST_MSG  = 2'd1;
	localparam ST_SIG  = 2'd2;
	reg [1:0]  state_q;
	reg [16:0] shift_q;
	reg [25:0] tmr_q;
	wire msg_hit = (shift_q[16:1] == `CIA_RAI_MSG);
	wire sig_hit = (shift_q == `CIA_RAI_SIG);
	////////////////////////////////////////////////////////////////////////////////
	// Phase timer checks each message run and signature run against its length.
	always @(posedge clk) begin
		if (srst || !enable) begin
			state_q   <= ST_HUNT;
			shift_q   <= 17'h0_0000;
			tmr_q     <= 26'h000_0000;
			present_q <= 1'b0;
		end else begin
			tmr_q <= (tmr_q == 26'h3ff_ffff) ? tmr_q : tmr_q + 26'h000_0001;
			if (dl_en)
				shift_q <= {dl_in, shift_q[16:1]};
			case (state_q)
			ST_HUNT: begin
				if (msg_hit) begin
					state_q <= ST_MSG;
					tmr_q   <= 26'h000_0000;
				end
			end
			ST_MSG: begin
				if (sig_hit) begin
					if (tmr_q + TOL_CYC >= MSG_CYC) begin
						state_q <= ST_SIG;
						tmr_q   <= 26'h000_0000;
					end else begin
						state_q <= ST_HUNT;
					end
				end else if (tmr_q > MSG_CYC + TOL_CYC) begin
					state_q   <= ST_HUNT;
					present_q <= 1'b0;
				end
			end
			ST_SIG: begin
				if (msg_hit && tmr_q + TOL_CYC >= SIG_CYC) begin
					state_q   <= ST_MSG;
					tmr_q     <= 26'h000_0000;
					present_q <= 1'b1;
				end else if (tmr_q > SIG_CYC + TOL_CYC) begin
					state_q   <= ST_HUNT;
					present_q <= 1'b0;
				end
			end
			default: state_q <= ST_HUNT;
			endcase
		end
	end
endmodule

// ==== logic/cia_monitor.v ====
// Customer-installation alarm monitor: two detectors, change flags, enables, IRQ.
// Assumes an Avalon-MM master, framed line bits with strobes, one clock.
//
// Notes on behaviour
// - Status bit 5 reads 1 while the AIS-CI condition is detected.
// - AIS-CI is all ones with signature 01111100 11111111, right to left, every 386 bits.
// - AIS-CI indication stays 0 unless AIS-CI detection is enabled.
// - Status bit 4 reads 1 while RAI-CI is declared, only in ESF framing.
// - RAI-CI repeats every 1.08 s: 0.99 s of RAI message then 90 ms of signature.
// - RAI message matches 00000000 11111111, signature 00111110 111111111, right to left.
// - RAI-CI indication stays 0 unless RAI-CI detection is enabled.
// - Status bit 1 latches on either edge of the AIS-CI condition.
// - Status bit 0 latches on either edge of the RAI-CI condition.
// - Reading the status register clears both change bits.
// - Enable bit 1 gates the AIS-CI change interrupt.
// - Enable bit 0 gates the RAI-CI change interrupt.
`timescale 1ns/10ps
`include "cia_consts.vh"
module cia_monitor #(
	parameter AIS_LOCK    = 4,
	parameter RAI_MSG_CYC = `CIA_RAI_MSG_MS * (`CIA_CLK_KHZ / 1000) * 1000,
	parameter RAI_SIG_CYC = `CIA_RAI_SIG_MS * (`CIA_CLK_KHZ / 1000) * 1000,
	parameter RAI_TOL_CYC = 100000
) (
	input  wire        clk,                // System clock, 20 MHz.
	input  wire        srst,               // Synchronous reset, active high.
	input  wire [13:0] avs_address,        // Byte address.
	input  wire        avs_read,           // Read request.
	input  wire        avs_write,          // Write request.
	input  wire [31:0] avs_writedata,      // Write data.
	input  wire [3:0]  avs_byteenable,     // Byte lanes.
	output reg  [31:0] avs_readdata,       // Read data.
	output reg         avs_waitrequest,    // Stall, high until the answer cycle.
	output reg         avs_response_err_q, // High with an unmapped answer.
	input  wire        line_bit_en,        // Pulse per received line bit.
	input  wire        line_bit,           // Received line bit.
	input  wire        dl_bit_en,          // Pulse per ESF data-link bit.
	input  wire        dl_bit,             // ESF data-link bit.
	output reg         irq_q               // Level interrupt.
);
	reg  [1:0] chg_q;      // Change flags, AIS in bit 1, RAI in bit 0.
	reg  [1:0] irq_en_q;   // Interrupt enables.
	reg  [2:0] det_ctrl_q; // Detection enables and ESF mode.
	reg        ais_last_q;
	reg        rai_last_q;
	reg        done_q;
	wire       ais_now;
	wire       rai_now;
	wire [11:0] idx = avs_address[13:2];
	wire       req = (avs_read | avs_write) & ~done_q;
	wire       hit_st = (idx == `CIA_IDX_STATUS);
	wire       hit_en = (idx == `CIA_IDX_ENABLE);
	wire       hit_dc = (idx == `CIA_IDX_DET_CTRL);
	wire       st_rd = req & avs_read & hit_st;
	wire       wr_en = req & avs_write & avs_byteenable[0];
	wire [1:0] evt = {ais_now ^ ais_last_q, rai_now ^ rai_last_q};
	////////////////////////////////////////////////////////////////////////////////
	// Detectors.
	cia_ais_det #(
		.PERIOD   (`CIA_AIS_PERIOD),
		.LOCK_CNT (AIS_LOCK)
	) u_ais (
		.clk       (clk),
		.srst      (srst),
		.enable    (det_ctrl_q[`CIA_BIT_AIS_DET_EN]),
		.bit_en    (line_bit_en),
		.bit_in    (line_bit),
		.present_q (ais_now)
	);
	cia_rai_det #(
		.MSG_CYC (RAI_MSG_CYC),
		.SIG_CYC (RAI_SIG_CYC),
		.TOL_CYC (RAI_TOL_CYC)
	) u_rai (
		.clk       (clk),
		.srst      (srst),
		.enable    (det_ctrl_q[`CIA_BIT_RAI_DET_EN] & det_ctrl_q[`CIA_BIT_ESF]),
		.dl_en     (dl_bit_en),
		.dl_in     (dl_bit),
		.present_q (rai_now)
	);
	////////////////////////////////////////////////////////////////////////////////
	// Change flags: an edge sets, a status read clears, and the set wins.
	always @(posedge clk) begin
		if (srst) begin
			ais_last_q <= 1'b0;
			rai_last_q <= 1'b0;
			chg_q      <= 2'b00;
		end else begin
			ais_last_q <= ais_now;
			rai_last_q <= rai_now;
			chg_q[`CIA_BIT_AIS_CHG] <= evt[1] | (chg_q[`CIA_BIT_AIS_CHG] & ~st_rd);
			chg_q[`CIA_BIT_RAI_CHG] <= evt[0] | (chg_q[`CIA_BIT_RAI_CHG] & ~st_rd);
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Register slave: one wait cycle, answer on the second cycle of a request.
	always @(posedge clk) begin
		if (srst) begin
			irq_en_q           <= 2'b00;
			det_ctrl_q         <= 3'b000;
			done_q             <= 1'b0;
			avs_waitrequest    <= 1'b1;
			avs_readdata       <= 32'h0000_0000;
			avs_response_err_q <= 1'b0;
			irq_q              <= 1'b0;
		end else begin
			irq_q <= |(chg_q & irq_en_q);
			done_q <= req;
			avs_waitrequest <= ~req;
			avs_response_err_q <= req & ~(hit_st | hit_en | hit_dc);
			if (wr_en && hit_en)
				irq_en_q <= avs_writedata[1:0];
			if (wr_en && hit_dc)
				det_ctrl_q <= avs_writedata[2:0];
			avs_readdata <= 32'h0000_0000;
			if (req && avs_read) begin
				if (hit_st)
					avs_readdata <= {26'h000_0000, ais_now, rai_now, 2'b00, chg_q};
				else if (hit_en)
					avs_readdata <= {30'h0000_0000, irq_en_q};
				else if (hit_dc)
					avs_readdata <= {29'h0000_0000, det_ctrl_q};
			end
		end
	end
endmodule

// ==== verification/cia_monitor_properties.sv ====
// Assertions on the alarm monitor's register port and interrupt.
// Sees only the top module's ports; bound after the module.
`timescale 1ns/10ps
module cia_chk (
	input wire        clk,                // Clock.
	input wire        srst,               // Reset.
	input wire [13:0] avs_address,        // Address.
	input wire        avs_read,           // Read.
	input wire        avs_write,          // Write.
	input wire [31:0] avs_readdata,       // Read data.
	input wire        avs_waitrequest,    // Stall.
	input wire        avs_response_err_q, // Error.
	input wire        irq_q               // Interrupt.
);
	// An index outside the three registers is unmapped.
	wire bad = avs_address[13:2] < 12'h0b40 || avs_address[13:2] > 12'h0b42;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	////////////////////////////////
	property p_rst; disable iff (1'b0) srst |=> avs_waitrequest && !irq_q; endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_take; (avs_read || avs_write) && avs_waitrequest && $past(avs_waitrequest)
		|=> !avs_waitrequest; endproperty
	a_take: assert property (p_take) else $error("no answer one cycle after take");
	property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_one: assert property (p_one) else $error("answer longer than one cycle");
	property p_why; !avs_waitrequest |-> avs_read || avs_write; endproperty
	a_why: assert property (p_why) else $error("answer without request");
	property p_hi; !avs_waitrequest && avs_read |-> avs_readdata[31:8] == 24'h00_0000; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
	property p_rsv; !avs_waitrequest && avs_read && avs_address == 14'h2d00
		|-> (avs_readdata & 32'h0000_00cc) == 32'h0000_0000; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved status bits set");
	property p_err; !avs_waitrequest |-> avs_response_err_q == bad; endproperty
	a_err: assert property (p_err) else $error("error flag wrong");
	property p_fall; $fell(irq_q) |-> $past(avs_read || avs_write); endproperty
	a_fall: assert property (p_fall) else $error("interrupt fell without access");
endmodule

bind cia_monitor cia_chk i_chk (.clk(clk), .srst(srst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .avs_response_err_q(avs_response_err_q),
	.irq_q(irq_q));

// ==== verification/cia_line_model.sv ====
// Far-side source: framed DS1 line bits and ESF data-link bits.
// Assumes one clock; both streams step on a strobe every second cycle.
`timescale 1ns/10ps
module cia_line_model #(
	parameter MSG = 400, // Message phase, cycles.
	parameter SIG = 80   // Signature phase, cycles.
) (
	input  wire clk,    // Clock.
	input  wire ais_on, // Send AIS-CI.
	input  wire rai_on, // Send RAI-CI.
	output reg  stb_q,  // Bit strobe.
	output reg  lb_q,   // Line bit.
	output reg  db_q    // Data-link bit.
);
	localparam [15:0] ais_sig = 16'h7cff;
	localparam [15:0] rai_msg = 16'h00ff;
	localparam [16:0] rai_sig = 17'h0_7dff;
	reg [8:0]  pos_q = 9'h000;
	reg [15:0] ph_q = 16'h0000;
	reg [4:0]  k_q = 5'h00;
	initial stb_q = 1'b0;
	initial lb_q = 1'b0;
	initial db_q = 1'b0;
	////////////////////////////////
	// First bit sent is bit 0; when idle both lines alternate.
	// Phases are counted in bits, and each phase starts its pattern at bit 0.
	always @(posedge clk) begin
		stb_q <= ~stb_q;
		if (!stb_q) begin
			ph_q <= (ph_q == (MSG + SIG) / 2 - 1) ? 16'h0000 : ph_q + 16'h0001;
			pos_q <= (pos_q == 9'h181) ? 9'h000 : pos_q + 9'h001;
			lb_q <= ais_on ? (pos_q > 9'h00f || ais_sig[pos_q[3:0]]) : pos_q[0];
			if (ph_q == (MSG + SIG) / 2 - 1 || ph_q == MSG / 2 - 1)
				k_q <= 5'h00;
			else if (ph_q < MSG / 2)
				k_q <= {1'b0, k_q[3:0] + 4'h1};
			else
				k_q <= (k_q == 5'h10) ? 5'h00 : k_q + 5'h01;
			db_q <= !rai_on ? ~db_q : (ph_q < MSG / 2) ? rai_msg[k_q[3:0]] : rai_sig[k_q];
		end
	end
endmodule

// ==== verification/test_ci_alarm_monitor.sv ====
// Self-checking bench for the alarm monitor.
// Drives the register port and line model; answers checked from a queue.
`timescale 1ns/10ps
module test_ci_alarm_monitor;
	reg         clk = 0;
	reg         srst = 1;
	reg  [13:0] adr = 0;
	reg         rd = 0;
	reg         wr = 0;
	reg  [31:0] wd = 0;
	reg         ais = 0;
	reg         rai = 0;
	reg  [31:0] rnd = 49;
	reg  [3:0]  be = 4'hf;
	wire [31:0] rdata;
	wire        wait_r, err, irq, stb, lb, db;
	reg  [32:0] q[$];
	integer     fails = 0;
	integer     total_checks = 0;
	integer     i, k;
	always #25 clk = ~clk;
	cia_monitor #(.AIS_LOCK(2), .RAI_MSG_CYC(400), .RAI_SIG_CYC(80), .RAI_TOL_CYC(20)) i_dut (
		.clk(clk), .srst(srst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
		.avs_waitrequest(wait_r), .avs_response_err_q(err), .line_bit_en(stb),
		.line_bit(lb), .dl_bit_en(stb), .dl_bit(db), .irq_q(irq));
	cia_line_model i_line (.clk(clk), .ais_on(ais), .rai_on(rai),
		.stb_q(stb), .lb_q(lb), .db_q(db));
	////////////////////////////////
	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input [32:0] seen, input [32:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	function [31:0] xs(input [31:0] v);
		xs = v ^ (v << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	// One bus transfer; the expected answer is noted for the monitor.
	task bus(input w, input [11:0] idx, input [31:0] d, input [32:0] exp);
		q.push_back(exp);
		@(posedge clk);
		adr <= {idx, 2'b00};
		rd <= !w;
		wr <= w;
		wd <= d;
		i = 0;
		do begin
			@(posedge clk);
			i = i + 1;
		end while (wait_r !== 1'b0 && i < 50);
		rd <= 0;
		wr <= 0;
		if (i == 50) begin
			fails = fails + 1;
			print_verdict;
		end
	endtask
	task wirq(input e, input integer n);
		for (i = 0; i < n && irq !== e; i = i + 1) @(posedge clk);
		chk({32'h0, irq}, {32'h0, e});
		if (irq !== e) print_verdict;
	endtask
	// Each answer is compared with the oldest note; writes check the error flag.
	always @(posedge clk) begin
		if (!srst && wait_r === 1'b0)
			chk({err, rd ? rdata : 32'h0}, q.size() ? q.pop_front() : 33'h1_ffff_ffff);
	end
	initial begin
		repeat (20) @(posedge clk);
		srst <= 0;
		bus(0, 12'h0b40, 0, 0);
		bus(0, 12'h0b41, 0, 0);
		bus(1, 12'h0b50, 1, {1'b1, 32'h0});
		bus(0, 12'h0b3f, 0, {1'b1, 32'h0});
		for (k = 0; k < 4; k = k + 1) begin
			rnd = xs(rnd);
			bus(1, 12'h0b41, {rnd[31:8], 6'h00, rnd[1:0]}, 0);
			bus(0, 12'h0b41, 0, {31'h0, rnd[1:0]});
		end
		bus(1, 12'h0b41, 3, 0);
		be <= 4'h0;
		bus(1, 12'h0b41, 0, 0);
		be <= 4'hf;
		bus(0, 12'h0b41, 0, 33'h03);
		ais <= 1;
		repeat (4000) @(posedge clk);
		chk({32'h0, irq}, 0);
		bus(0, 12'h0b40, 0, 0);
		bus(1, 12'h0b41, 1, 0);
		bus(1, 12'h0b42, 1, 0);
		repeat (4000) @(posedge clk);
		chk({32'h0, irq}, 0);
		bus(1, 12'h0b41, 2, 0);
		wirq(1, 10);
		bus(0, 12'h0b40, 0, 33'h22);
		wirq(0, 10);
		bus(0, 12'h0b40, 0, 33'h20);
		ais <= 0;
		wirq(1, 3000);
		bus(0, 12'h0b40, 0, 33'h02);
		bus(1, 12'h0b41, 1, 0);
		bus(1, 12'h0b42, 4, 0);
		rai <= 1;
		repeat (2000) @(posedge clk);
		chk({32'h0, irq}, 0);
		bus(1, 12'h0b42, 6, 0);
		wirq(1, 3000);
		bus(0, 12'h0b40, 0, 33'h11);
		bus(0, 12'h0b40, 0, 33'h10);
		print_verdict;
	end
endmodule
